// ==== rtl/kccs_pkg.sv ====
/*
  Package for the Kelvin contact check sequencer: thresholds, status bit positions,
  timeout scaling and state encodings.
  Assumes a single 10 MHz system clock.
*/
package kccs_pkg;
  localparam int          KCCS_CLK_HZ      = 10_000_000;
  localparam int          KCCS_RES_W       = 16;          // Resistance result, whole ohms
  localparam int          KCCS_NPAIR       = 3;           // Force/sense lead pairs
  localparam int          KCCS_TMO_W       = 24;          // Timeout in 100 us units
  localparam int          KCCS_TICK_US     = 100;         // Timeout unit, microseconds
  localparam int          KCCS_TICK_CYC    = (KCCS_CLK_HZ / 1_000_000) * KCCS_TICK_US;
  localparam int          KCCS_TICK_W      = 10;
  localparam logic [23:0] KCCS_TMO_MAX     = 24'h98967F;  // 999.9999 s in 100 us units
  localparam int          KCCS_CHECK_US    = 350;         // Shortest complete check
  localparam int          KCCS_CHECK_CYC   = (KCCS_CLK_HZ / 1_000_000) * KCCS_CHECK_US;
  // Threshold selection codes and values
  localparam logic [1:0]  KCCS_THR_SEL_2   = 2'h0;
  localparam logic [1:0]  KCCS_THR_SEL_15  = 2'h1;
  localparam logic [1:0]  KCCS_THR_SEL_50  = 2'h2;
  localparam logic [1:0]  KCCS_THR_SEL_RST = KCCS_THR_SEL_50;
  localparam logic [15:0] KCCS_THR_2       = 16'h0002;
  localparam logic [15:0] KCCS_THR_15      = 16'h000F;
  localparam logic [15:0] KCCS_THR_50      = 16'h0032;
  // Status word and measurement register positions
  localparam int          KCCS_SW_W        = 24;
  localparam int          KCCS_SW_OPEN_BIT = 18;
  localparam int          KCCS_SW_L4F_BIT  = 19;
  localparam int          KCCS_MEAS_W      = 16;
  localparam int          KCCS_MEAS_BIT    = 10;
  localparam int          KCCS_PAT_W       = 4;
  typedef enum logic [5:0] {
    KCCS_IDLE  = 6'h01,
    KCCS_SKIP  = 6'h02,
    KCCS_START = 6'h04,
    KCCS_WAIT  = 6'h08,
    KCCS_FAILW = 6'h10,
    KCCS_DONE  = 6'h20
  } kccs_state_t;
endpackage

// ==== rtl/kccs_cmp_if.sv ====
/*
  Interface carrying lead pair results between the sequencer and its comparator.
  Assumes both ends run on mclk.
*/
`timescale 1ns/1ns
interface kccs_cmp_if;
  import kccs_pkg::*;
  logic [KCCS_NPAIR*KCCS_RES_W-1:0] res;
  logic [KCCS_RES_W-1:0]            thr;
  logic                             load;
  logic                             pass;
  logic                             valid;
  modport seq (output res, output thr, output load, input pass, input valid);
  modport cmp (input res, input thr, input load, output pass, output valid);
endinterface // kccs_cmp_if

// ==== rtl/kccs_cmp.sv ====
/*
  Lead pair comparator: registers the pass result of all pairs against a threshold.
  Assumes results are held stable while load is high.
*/
`timescale 1ns/1ns
module kccs_cmp
  import kccs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  kccs_cmp_if.cmp   cif
);
  logic [KCCS_NPAIR-1:0] below;
  logic                  pass_q;
  logic                  valid_q;

  // One strict comparison per lead pair
  genvar g;
  generate
    for (g = 0; g < KCCS_NPAIR; g++) begin : g_pair
      assign below[g] = cif.res[g*KCCS_RES_W +: KCCS_RES_W] < cif.thr;
    end
  endgenerate

  // Any pair at or above threshold fails the check
  always_ff @(posedge mclk) begin
    if (reset) begin
      pass_q  <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= cif.load;
      if (cif.load) begin
        pass_q <= &below;
      end
    end
  end

  assign cif.pass  = pass_q;
  assign cif.valid = valid_q;
endmodule // kccs_cmp

// ==== rtl/kccs_seq.sv ====
/*
  Kelvin contact check sequencer: gates the trigger layer source step on a contact
  check, times out failures and drives the failure indications.
  Assumes the resistance front end delivers three results with a done strobe, all on mclk.
*/
`timescale 1ns/1ns
module kccs_seq
  import kccs_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         reset,
  input  wire logic                         cc_enable,
  input  wire logic [1:0]                   cc_thr_sel,
  input  wire logic                         cc_thr_load,
  input  wire logic                         four_wire,
  input  wire logic                         evt_det_enable,
  input  wire logic [KCCS_TMO_W-1:0]        evt_timeout,
  input  wire logic                         lim4_enable,
  input  wire logic [KCCS_PAT_W-1:0]        lim4_fail_pattern,
  input  wire logic                         trig_reach,
  output logic                              meas_start,
  input  wire logic                         meas_done,
  input  wire logic [KCCS_NPAIR*KCCS_RES_W-1:0] meas_res,
  output logic                              source_go,
  output logic                              limits_go,
  output logic                              open_lead_flag,
  output logic [KCCS_PAT_W-1:0]             dio_out,
  output logic                              dio_out_valid,
  output logic [KCCS_SW_W-1:0]              status_word,
  output logic [KCCS_MEAS_W-1:0]            meas_cond,
  output logic [KCCS_MEAS_W-1:0]            meas_event,
  input  wire logic                         meas_event_clr,
  output logic [1:0]                        thr_sel_out,
  output logic                              det_active,
  output logic                              busy
);
  kccs_cmp_if  cif ();
  kccs_state_t state_q;
  kccs_state_t state_d;
  logic [1:0]            thr_sel_q;
  logic [KCCS_TMO_W-1:0] tmo_cnt_q;
  logic [KCCS_TICK_W-1:0] tick_cnt_q;
  logic                  tick;
  logic                  det_en_eff;
  logic                  check_on;
  logic                  tmo_zero;
  logic                  tmo_hit;
  logic                  failed_q;
  logic                  open_q;
  logic                  lim4_fail_q;
  logic                  lim4_pass_q;
  logic [KCCS_PAT_W-1:0] dio_q;
  logic                  dio_v_q;
  logic                  evt_q;
  logic                  source_go_q;
  logic                  limits_go_q;
  logic [KCCS_TMO_W-1:0] tmo_clip;
  logic                  fail_evt;

  // Threshold decode
  function automatic logic [KCCS_RES_W-1:0] thr_of(input logic [1:0] sel);
    case (sel)
      KCCS_THR_SEL_2:  thr_of = KCCS_THR_2;
      KCCS_THR_SEL_15: thr_of = KCCS_THR_15;
      default:         thr_of = KCCS_THR_50;
    endcase
  endfunction

  kccs_cmp u_cmp (
    .mclk  (mclk),
    .reset (reset),
    .cif   (cif)
  );

  // Comparator feed
  assign cif.res  = meas_res;
  assign cif.thr  = thr_of(thr_sel_q);
  assign cif.load = (state_q == KCCS_WAIT || state_q == KCCS_FAILW) && meas_done;

  // Threshold selection register, 50 ohm after reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      thr_sel_q <= KCCS_THR_SEL_RST;
    end else if (cc_thr_load && cc_thr_sel != 2'h3) begin
      thr_sel_q <= cc_thr_sel;
    end
  end

  // Qualifiers: check only in four-wire, detection forced off otherwise
  assign check_on   = cc_enable && four_wire;
  assign det_en_eff = evt_det_enable && check_on;
  assign tmo_clip   = (evt_timeout > KCCS_TMO_MAX) ? KCCS_TMO_MAX : evt_timeout;
  assign tmo_zero   = (tmo_clip == '0);
  assign tick       = (tick_cnt_q == KCCS_TICK_W'(KCCS_TICK_CYC - 1));
  assign tmo_hit    = !tmo_zero && tick && (tmo_cnt_q == tmo_clip - KCCS_TMO_W'(1));
  assign fail_evt   = cif.valid && !cif.pass;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      KCCS_IDLE: begin
        if (trig_reach) begin
          state_d = check_on ? KCCS_START : KCCS_SKIP;
        end
      end
      KCCS_SKIP: state_d = KCCS_DONE;
      KCCS_START: state_d = KCCS_WAIT;
      KCCS_WAIT: begin
        if (cif.valid && cif.pass) begin
          state_d = KCCS_DONE;
        end else if (fail_evt) begin
          state_d = det_en_eff ? KCCS_FAILW : KCCS_DONE;
        end else if (!det_en_eff) begin
          state_d = KCCS_WAIT;                         // Result still needed for flags
        end else if (tmo_hit) begin
          state_d = KCCS_DONE;
        end
      end
      KCCS_FAILW: begin
        if (tmo_hit) begin
          state_d = KCCS_DONE;
        end else if (tmo_zero && cif.valid && cif.pass) begin
          state_d = KCCS_DONE;
        end
      end
      KCCS_DONE: state_d = KCCS_IDLE;
      default:   state_d = KCCS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= KCCS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Timeout prescaler and counter, live in KCCS_WAIT and KCCS_FAILW, detection on or off
  always_ff @(posedge mclk) begin
    if (reset || !(state_q == KCCS_WAIT || state_q == KCCS_FAILW) || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + KCCS_TICK_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !(state_q == KCCS_WAIT || state_q == KCCS_FAILW)) begin
      tmo_cnt_q <= '0;
    end else if (tick) begin
      tmo_cnt_q <= tmo_cnt_q + KCCS_TMO_W'(1);
    end
  end

  // Failure capture for the current trigger pass
  always_ff @(posedge mclk) begin
    if (reset || state_q == KCCS_START || state_q == KCCS_SKIP) begin
      failed_q <= 1'b0; // A skipped check must not report an old failure
    end else if (fail_evt) begin
      failed_q <= 1'b1;
    end
  end

  // Open lead flag and limit 4 result, updated at the end of each check
  always_ff @(posedge mclk) begin
    if (reset) begin
      open_q      <= 1'b0;
      lim4_fail_q <= 1'b0;
      lim4_pass_q <= 1'b0;
    end else if (state_q == KCCS_DONE) begin
      open_q      <= failed_q;
      lim4_fail_q <= lim4_enable && failed_q;
      lim4_pass_q <= lim4_enable && !failed_q;
    end
  end

  // Digital output pattern on limit 4 failure
  always_ff @(posedge mclk) begin
    if (reset) begin
      dio_q   <= '0;
      dio_v_q <= 1'b0;
    end else if (state_q == KCCS_DONE) begin
      dio_q   <= (lim4_enable && failed_q) ? lim4_fail_pattern : '0;
      dio_v_q <= lim4_enable && failed_q;
    end
  end

  // Sticky event bit; a failure in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      evt_q <= 1'b0;
    end else if (state_q == KCCS_DONE && failed_q) begin
      evt_q <= 1'b1;
    end else if (meas_event_clr) begin
      evt_q <= 1'b0;
    end
  end

  // Step releases: contact limit and source action in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      source_go_q <= 1'b0;
      limits_go_q <= 1'b0;
    end else begin
      source_go_q <= (state_q == KCCS_DONE);
      limits_go_q <= (state_q == KCCS_DONE);
    end
  end

  // Status word: open lead bit and limit 4 fail bit
  always_comb begin
    status_word                   = '0;
    status_word[KCCS_SW_OPEN_BIT] = lim4_enable && open_q;
    status_word[KCCS_SW_L4F_BIT]  = lim4_fail_q;
    meas_cond                     = '0;
    meas_cond[KCCS_MEAS_BIT]      = open_q;
    meas_event                    = '0;
    meas_event[KCCS_MEAS_BIT]     = evt_q;
  end

  // No energy applied: only a measurement request leaves here
  assign meas_start     = (state_q == KCCS_START);
  assign source_go      = source_go_q;
  assign limits_go      = limits_go_q;
  assign open_lead_flag = open_q;
  assign dio_out        = dio_q;
  assign dio_out_valid  = dio_v_q;
  assign thr_sel_out    = thr_sel_q;
  assign det_active     = (state_q == KCCS_WAIT || state_q == KCCS_FAILW) && det_en_eff;
  assign busy           = (state_q != KCCS_IDLE);
endmodule // kccs_seq

// ==== verif/kccs_seq_props.sv ====
/*
  Checker for the contact check sequencer, watching only its top ports.
  Assumes one clock, mclk, and a synchronous active high reset.
*/
`timescale 1ns/1ns
module kccs_seq_props
  import kccs_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   reset,
  input wire logic                   cc_enable,
  input wire logic [1:0]             cc_thr_sel,
  input wire logic                   cc_thr_load,
  input wire logic                   four_wire,
  input wire logic [KCCS_PAT_W-1:0]  lim4_fail_pattern,
  input wire logic                   trig_reach,
  input wire logic                   meas_start,
  input wire logic                   source_go,
  input wire logic                   limits_go,
  input wire logic                   open_lead_flag,
  input wire logic [KCCS_PAT_W-1:0]  dio_out,
  input wire logic                   dio_out_valid,
  input wire logic [KCCS_SW_W-1:0]   status_word,
  input wire logic [KCCS_MEAS_W-1:0] meas_cond,
  input wire logic [KCCS_MEAS_W-1:0] meas_event,
  input wire logic                   meas_event_clr,
  input wire logic [1:0]             thr_sel_out,
  input wire logic                   det_active,
  input wire logic                   busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Threshold select and its default
  a_thr_default:
    assert property ($fell(reset) |-> thr_sel_out == KCCS_THR_SEL_RST)
      else $error("threshold select not default");
  a_thr_load:
    assert property (cc_thr_load && cc_thr_sel != 2'h3 |=> thr_sel_out == $past(cc_thr_sel))
      else $error("threshold select not loaded");
  // Check start and skip paths
  a_check_start:
    assert property (trig_reach && !busy && cc_enable && four_wire |=> meas_start)
      else $error("check not started");
  a_skip_quick:
    assert property (trig_reach && !busy && !(cc_enable && four_wire) |=> !meas_start ##2 source_go)
      else $error("skipped check not released");
  // Release pulses
  a_limits_with_src:
    assert property (source_go |-> limits_go) else $error("limits not run with source");
  a_src_single:
    assert property (source_go |=> !source_go) else $error("source release too long");
  // Failure indications
  a_event_sticky:
    assert property (meas_event[KCCS_MEAS_BIT] && !meas_event_clr |=> meas_event[KCCS_MEAS_BIT])
      else $error("event bit lost");
  a_cond_event:
    assert property ($rose(meas_cond[KCCS_MEAS_BIT]) |-> meas_event[KCCS_MEAS_BIT])
      else $error("event bit not set");
  a_dio_pattern:
    assert property (dio_out_valid |-> dio_out == lim4_fail_pattern) else $error("wrong fail pattern");
  a_open_status:
    assert property (status_word[KCCS_SW_OPEN_BIT] |-> open_lead_flag) else $error("status open bit without flag");
  // Detector only active for an enabled four-wire check
  a_det_forced_off:
    assert property (det_active |-> cc_enable && four_wire) else $error("detector active without check");
  // Nothing released straight out of reset
  a_reset_quiet:
    assert property ($fell(reset) |-> !source_go && !busy) else $error("release out of reset");
endmodule // kccs_seq_props
bind kccs_seq kccs_seq_props u_kccs_seq_props (.mclk, .reset, .cc_enable, .cc_thr_sel, .cc_thr_load,
  .four_wire, .lim4_fail_pattern, .trig_reach, .meas_start, .source_go, .limits_go, .open_lead_flag,
  .dio_out, .dio_out_valid, .status_word, .meas_cond, .meas_event, .meas_event_clr, .thr_sel_out,
  .det_active, .busy);

// ==== verif/kccs_fe_model.sv ====
/*
  Resistance front end model: answers a start request with three results.
  Assumes requests come from the sequencer on mclk.
*/
`timescale 1ns/1ns
module kccs_fe_model
  import kccs_pkg::*;
#(
  parameter int DLY = 20
)
(
  input  wire logic        mclk,
  input  wire logic        meas_start,
  input  wire logic [47:0] res,
  output logic             meas_done,
  output logic [47:0]      meas_res
);
  int cnt = 0;
  initial meas_done = 1'b0;
  initial meas_res = 48'h0;
  // Fixed range measurement, no auto ranging; results toggle when not valid
  always @(posedge mclk) begin
    meas_done <= 1'b0;
    meas_res  <= ~meas_res;
    if (meas_start) begin
      cnt <= DLY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        meas_done <= 1'b1;
        meas_res  <= res;
      end
    end
  end
endmodule // kccs_fe_model

// ==== verif/testbench.sv ====
/*
  Testbench for the contact check sequencer with a front end model.
  Assumes a 10 MHz mclk; inputs change at the falling edge.
*/
`timescale 1ns/1ns
module testbench;
  import kccs_pkg::*;
  logic mclk = 0, reset = 1, cc_enable = 1, cc_thr_load = 0, four_wire = 1, evt_det_enable = 0;
  logic lim4_enable = 1, trig_reach = 0, meas_event_clr = 0;
  logic [1:0]  cc_thr_sel = 2'h2;
  logic [23:0] evt_timeout = 24'h0;
  logic [3:0]  lim4_fail_pattern = 4'hA;
  logic [47:0] res = 48'h0, meas_res, r;
  logic meas_start, meas_done, source_go, limits_go, open_lead_flag, dio_out_valid, det_active, busy;
  logic [3:0]  dio_out;
  logic [23:0] status_word;
  logic [15:0] meas_cond, meas_event;
  logic [1:0]  thr_sel_out;
  int bad_count = 0, checked = 0, n;
  always #50 mclk = ~mclk;
  kccs_seq u_kccs_seq (.mclk, .reset, .cc_enable, .cc_thr_sel, .cc_thr_load, .four_wire, .evt_det_enable,
    .evt_timeout, .lim4_enable, .lim4_fail_pattern, .trig_reach, .meas_start, .meas_done, .meas_res,
    .source_go, .limits_go, .open_lead_flag, .dio_out, .dio_out_valid, .status_word, .meas_cond,
    .meas_event, .meas_event_clr, .thr_sel_out, .det_active, .busy);
  kccs_fe_model #(.DLY(20)) u_kccs_fe_model (.mclk, .meas_start, .res, .meas_done, .meas_res);
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("Counts: %0d checks, %0d mismatches", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset;
    reset = 1;
    repeat (20) @(negedge mclk);
    reset = 0;
    @(negedge mclk);
  endtask
  // One trigger, then wait for the source release; n counts the cycles
  task automatic run(input logic [47:0] v);
    res = v;
    n = 0;
    trig_reach = 1;
    @(negedge mclk);
    trig_reach = 0;
    while (source_go !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 5000) chk(24'h0, 24'h1);
    @(negedge mclk);
  endtask
  task automatic thr(input logic [1:0] c);
    cc_thr_sel = c;
    cc_thr_load = 1;
    @(negedge mclk);
    cc_thr_load = 0;
    @(negedge mclk);
  endtask
  initial begin
    do_reset;
    chk(thr_sel_out, 2'h2);
    chk({open_lead_flag, dio_out_valid, status_word[18]}, 3'h0);
    for (int c = 0; c < 4; c++) begin
      thr(c[1:0]);
      chk(thr_sel_out, (c == 3) ? 2'h2 : c[1:0]);
    end
    $display("test thresholds done");
    evt_det_enable = 1;
    run({3{16'h0031}});
    chk({open_lead_flag, meas_cond[10]}, 2'h0);
    chk(n < 100, 1'b1);
    evt_det_enable = 0;
    for (int i = 0; i < 3; i++) begin
      r = {3{16'h0031}};
      r[i*16 +: 16] = 16'h0032;
      run(r);
      chk({open_lead_flag, status_word[18], dio_out_valid, dio_out}, 7'h7A);
      chk({meas_cond[10], meas_event[10], 1'b0}, 3'h6);
      chk(n < 100, 1'b1);
    end
    $display("test pair fails done");
    thr(2'h0);
    run({3{16'h0001}});
    chk(open_lead_flag, 1'b0);
    meas_event_clr = 1;
    @(negedge mclk);
    meas_event_clr = 0;
    @(negedge mclk);
    chk(meas_event[10], 1'b0);
    lim4_enable = 0;
    run({3{16'h0002}});
    chk({open_lead_flag, status_word[18], dio_out_valid}, 3'h4);
    lim4_enable = 1;
    $display("test limit enable done");
    evt_det_enable = 1;
    evt_timeout = 24'h1;
    run({3{16'h0002}});
    chk(n >= 1000 && n < 1010, 1'b1);
    chk(open_lead_flag, 1'b1);
    $display("test timeout done");
    four_wire = 0;
    run({3{16'h0002}});
    chk(n[23:0], 24'h2);
    chk({open_lead_flag, dio_out_valid}, 2'h0);
    four_wire = 1;
    cc_enable = 0;
    run({3{16'h0002}});
    chk(n[23:0], 24'h2);
    cc_enable = 1;
    $display("test skip done");
    evt_timeout = 24'h0;
    res = {3{16'h0002}};
    trig_reach = 1;
    @(negedge mclk);
    trig_reach = 0;
    n = 0;
    repeat (3000) begin
      @(negedge mclk);
      if (source_go === 1'b1) n++;
    end
    chk(n[23:0], 24'h0);
    chk(busy, 1'b1);
    do_reset;
    chk({thr_sel_out, source_go, busy}, 4'h8);
    $display("test zero timeout done");
    end_of_test;
  end
  // Watchdog against a hung sequence
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    end_of_test;
  end
endmodule // testbench
